// ### aout_channel_ctrl.sv
// analog output channel control: validity, clamp, ramp, hold, echo, fault action
//
// Behaviour
// - request is in engineering units, scaled by channel gain and offset to DAC code.
// - echo equals request except in program, comm fault, clamp, ramp or hold conditions.
// - invalid-number flag set when request is not a valid IEEE float.
// - invalid request ignored; last valid value keeps driving the output.
// - hold keeps output and flags it until request within 0.1% full scale.
// - with ramp-in-run, ramp alarm sets when step exceeds maximum slew rate.
// - ramp alarm clears when ramping ends unless ramp alarm latching is on.
// - request below low limit sets low alarm, output and echo clamp low.
// - low alarm holds until request rises above limit, or latches if enabled.
// - request above high limit sets high alarm, output and echo clamp high.
// - high alarm holds until request falls below limit, or latches if enabled.
// - group fault flag raised whenever the channel reports a fault.
// - program mode comm fault with enable set drives the fault value.
// - program mode comm fault with enable clear keeps program value.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
module aout_channel_ctrl #(
  parameter int UPDATE_CYCLES = aout_pkg::UPDATE_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PROGRAM_MODE,
  input wire logic COMM_FAULT,
  output logic [15:0] DAC_CODE,
  output logic OUTPUT_HOLD_FLAG,
  output logic OUTPUT_GROUP_FAULT,
  output logic IRQ
);
  function automatic logic signed [31:0] f2x(input logic [31:0] f);
    logic [54:0] m;
    logic [31:0] mag;
    m = {31'h0, 1'b1, f[22:0]};
    if (f[30:23] < 8'd103) mag = 32'h0;
    else if (f[30:23] >= 8'd142) mag = 32'h7FFFFFFF;
    else if (f[30:23] >= 8'd134) mag = 32'(m << (f[30:23] - 8'd134));
    else mag = 32'(m >> (8'd134 - f[30:23]));
    return f[31] ? -$signed(mag) : $signed(mag);
  endfunction : f2x

  function automatic logic [31:0] x2f(input logic signed [31:0] x);
    logic [31:0] mag;
    logic [31:0] nrm;
    logic [7:0] p;
    mag = x[31] ? 32'(-x) : 32'(x);
    p = 8'h0;
    for (int i = 0; i < 32; i++) if (mag[i]) p = 8'(i);
    nrm = mag << (8'd31 - p);
    if (mag == 32'h0) return 32'h0;
    return {x[31], 8'(p + 8'd111), nrm[30:8]};
  endfunction : x2f

  logic [1:0] prog_sync, fault_sync;
  logic prog_mode, comm_fault, prog_q;
  logic [31:0] req_reg, low_reg, high_reg, slew_reg, fval_reg, pval_reg;
  logic [31:0] gain_reg, offset_reg, full_reg;
  logic [3:0] ctrl_reg;
  logic [4:0] irq_stat_reg, irq_mask_reg, irq_ev;
  logic signed [31:0] out_reg, out_next, target, lo_x, hi_x, sl_x, diff;
  logic [31:0] tol;
  logic [63:0] scaled;
  logic [31:0] tick_cnt;
  logic tick, wr, rd, wr_req, req_bad, unl_ramp, unl_clamp;
  logic below, above, ramping, matched, hold_now;
  aout_pkg::flags_t flg_reg;

  // two-flop synchronisers for the mode and fault pins
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      prog_sync <= 2'b00;
      fault_sync <= 2'b00;
      prog_q <= 1'b0;
    end else begin
      prog_sync <= {prog_sync[0], PROGRAM_MODE};
      fault_sync <= {fault_sync[0], COMM_FAULT};
      prog_q <= prog_sync[1];
    end
  end
  assign prog_mode = prog_sync[1];
  assign comm_fault = fault_sync[1];

  // update period divider
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) tick_cnt <= 32'h0;
    else if (tick) tick_cnt <= 32'h0;
    else tick_cnt <= tick_cnt + 32'h1;
  end
  assign tick = tick_cnt == 32'(UPDATE_CYCLES - 1);

  // apb: one wait state, answer in second access cycle
  assign wr = PSEL && PENABLE && PWRITE && !PREADY;
  assign rd = PSEL && PENABLE && !PWRITE && !PREADY;
  assign wr_req = wr && PADDR == aout_pkg::OFS_REQ;
  assign req_bad = PWDATA[30:23] == 8'hFF;
  assign unl_ramp = wr && PADDR == aout_pkg::OFS_CTRL && PWDATA[aout_pkg::CTL_UNL_RAMP];
  assign unl_clamp = wr && PADDR == aout_pkg::OFS_CTRL && PWDATA[aout_pkg::CTL_UNL_CLAMP];

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      req_reg <= aout_pkg::ZERO_RST;
      low_reg <= aout_pkg::LOW_RST;
      high_reg <= aout_pkg::HIGH_RST;
      slew_reg <= aout_pkg::SLEW_RST;
      fval_reg <= aout_pkg::ZERO_RST;
      pval_reg <= aout_pkg::ZERO_RST;
      gain_reg <= aout_pkg::GAIN_RST;
      offset_reg <= aout_pkg::ZERO_RST;
      full_reg <= aout_pkg::FULL_RST;
      ctrl_reg <= aout_pkg::CTRL_RST;
      irq_mask_reg <= aout_pkg::IRQ_RST;
    end else if (wr) begin
      case (PADDR)
        aout_pkg::OFS_REQ: if (!req_bad) req_reg <= PWDATA;
        aout_pkg::OFS_LOW: low_reg <= PWDATA;
        aout_pkg::OFS_HIGH: high_reg <= PWDATA;
        aout_pkg::OFS_SLEW: slew_reg <= PWDATA;
        aout_pkg::OFS_FAULT_VAL: fval_reg <= PWDATA;
        aout_pkg::OFS_PROG_VAL: pval_reg <= PWDATA;
        aout_pkg::OFS_GAIN: gain_reg <= PWDATA;
        aout_pkg::OFS_OFFSET: offset_reg <= PWDATA;
        aout_pkg::OFS_FULL: full_reg <= PWDATA;
        aout_pkg::OFS_CTRL: ctrl_reg <= PWDATA[3:0];
        aout_pkg::OFS_IRQ_MASK: irq_mask_reg <= PWDATA[4:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && PADDR > aout_pkg::OFS_CODE;
      if (rd) begin
        case (PADDR)
          aout_pkg::OFS_REQ: PRDATA <= req_reg;
          aout_pkg::OFS_ECHO: PRDATA <= x2f(out_reg);
          aout_pkg::OFS_FLAGS: PRDATA <= {26'h0, flg_reg};
          aout_pkg::OFS_CTRL: PRDATA <= {28'h0, ctrl_reg};
          aout_pkg::OFS_LOW: PRDATA <= low_reg;
          aout_pkg::OFS_HIGH: PRDATA <= high_reg;
          aout_pkg::OFS_SLEW: PRDATA <= slew_reg;
          aout_pkg::OFS_FAULT_VAL: PRDATA <= fval_reg;
          aout_pkg::OFS_PROG_VAL: PRDATA <= pval_reg;
          aout_pkg::OFS_GAIN: PRDATA <= gain_reg;
          aout_pkg::OFS_OFFSET: PRDATA <= offset_reg;
          aout_pkg::OFS_FULL: PRDATA <= full_reg;
          aout_pkg::OFS_IRQ_STAT: PRDATA <= {27'h0, irq_stat_reg};
          aout_pkg::OFS_IRQ_MASK: PRDATA <= {27'h0, irq_mask_reg};
          aout_pkg::OFS_CODE: PRDATA <= {16'h0, DAC_CODE};
          default: PRDATA <= 32'h0;
        endcase
      end
    end
  end

  // target selection and comparisons in Q16.16
  assign lo_x = f2x(low_reg);
  assign hi_x = f2x(high_reg);
  assign sl_x = f2x(slew_reg);
  assign below = f2x(req_reg) < lo_x;
  assign above = f2x(req_reg) > hi_x;
  always_comb begin
    if (prog_mode && comm_fault && ctrl_reg[aout_pkg::CTL_PCF_EN]) target = f2x(fval_reg);
    else if (prog_mode) target = f2x(pval_reg);
    else if (comm_fault) target = f2x(fval_reg);
    else if (below) target = lo_x;
    else if (above) target = hi_x;
    else target = f2x(req_reg);
  end
  assign diff = target - out_reg;
  // gap larger than the slew rate
  assign ramping = ctrl_reg[aout_pkg::CTL_RAMP_EN] && !prog_mode
    && (diff > sl_x || -diff > sl_x);
  assign tol = 32'((64'(f2x(full_reg) & 32'h7FFFFFFF) * 64'(aout_pkg::HOLD_TOL_MUL)) >> 24);
  // match within 0.1 percent of full scale
  assign matched = (diff < 0 ? 32'(-diff) : 32'(diff)) <= tol;

  // freeze also in the cycle the mode falls, before the hold flag is up
  assign hold_now = flg_reg.hold || (prog_q && !prog_mode);
  always_comb begin
    out_next = out_reg;
    if (hold_now) out_next = out_reg;
    else if (ramping) out_next = diff > 0 ? out_reg + sl_x : out_reg - sl_x;
    else out_next = target;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) out_reg <= 32'h0;
    else if (tick) out_reg <= out_next;
  end

  assign scaled = 64'(signed'(out_reg - $signed(offset_reg))) * 64'(signed'(gain_reg));
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) DAC_CODE <= 16'h0;
    else DAC_CODE <= scaled[47:32];
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) flg_reg <= '0;
    else begin
      // set on bad value, cleared by next valid one
      if (wr_req) flg_reg.invalid <= req_bad;
      // enter hold when leaving program mode, leave on match
      if (prog_q && !prog_mode) flg_reg.hold <= 1'b1;
      else if (tick && flg_reg.hold && matched) flg_reg.hold <= 1'b0;
      // ramp alarm, set wins over unlatch
      if (ramping) flg_reg.ramp <= 1'b1;
      else if (!ctrl_reg[aout_pkg::CTL_SLEW_LATCH] || unl_ramp) flg_reg.ramp <= 1'b0;
      if (below) flg_reg.low <= 1'b1;
      else if (!ctrl_reg[aout_pkg::CTL_CLAMP_LATCH] || unl_clamp) flg_reg.low <= 1'b0;
      if (above) flg_reg.high <= 1'b1;
      else if (!ctrl_reg[aout_pkg::CTL_CLAMP_LATCH] || unl_clamp) flg_reg.high <= 1'b0;
      flg_reg.group_fault <= flg_reg.invalid | flg_reg.ramp | flg_reg.low | flg_reg.high;
    end
  end

  assign irq_ev = {above && !flg_reg.high, below && !flg_reg.low, ramping && !flg_reg.ramp,
    tick && flg_reg.hold && matched, wr_req && req_bad};
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      irq_stat_reg <= aout_pkg::IRQ_RST;
      IRQ <= 1'b0;
    end else begin
      // events win over a write-one-to-clear in the same cycle
      irq_stat_reg <= irq_ev | (irq_stat_reg
        & ~((wr && PADDR == aout_pkg::OFS_IRQ_STAT) ? PWDATA[4:0] : 5'h0));
      IRQ <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      OUTPUT_HOLD_FLAG <= 1'b0;
      OUTPUT_GROUP_FAULT <= 1'b0;
    end else begin
      OUTPUT_HOLD_FLAG <= flg_reg.hold;
      OUTPUT_GROUP_FAULT <= flg_reg.group_fault;
    end
  end

  property p_invalid_set;
    @(posedge SYS_CLK) disable iff (RST) wr_req && req_bad |=> flg_reg.invalid;
  endproperty
  a_invalid_set: assert property (p_invalid_set) else $error("invalid flag not set");
  property p_keep_valid;
    @(posedge SYS_CLK) disable iff (RST) wr_req && req_bad |=> req_reg == $past(req_reg);
  endproperty
  a_keep_valid: assert property (p_keep_valid) else $error("invalid value stored");
  property p_hold_out;
    @(posedge SYS_CLK) disable iff (RST) flg_reg.hold && tick |=> $stable(out_reg);
  endproperty
  a_hold_out: assert property (p_hold_out) else $error("output moved in hold");
  property p_ramp_set;
    @(posedge SYS_CLK) disable iff (RST) ramping |=> flg_reg.ramp;
  endproperty
  a_ramp_set: assert property (p_ramp_set) else $error("ramp alarm missing");
  property p_ramp_clr;
    @(posedge SYS_CLK) disable iff (RST)
      !ramping && !ctrl_reg[aout_pkg::CTL_SLEW_LATCH] |=> !flg_reg.ramp;
  endproperty
  a_ramp_clr: assert property (p_ramp_clr) else $error("ramp alarm stuck");
  property p_low;
    @(posedge SYS_CLK) disable iff (RST) below && !prog_mode && !comm_fault |-> target == lo_x;
  endproperty
  a_low: assert property (p_low) else $error("low clamp wrong");
  property p_high;
    @(posedge SYS_CLK) disable iff (RST) above |=> flg_reg.high;
  endproperty
  a_high: assert property (p_high) else $error("high alarm missing");
  property p_latch;
    @(posedge SYS_CLK) disable iff (RST)
      flg_reg.low && ctrl_reg[aout_pkg::CTL_CLAMP_LATCH] && !unl_clamp |=> flg_reg.low;
  endproperty
  a_latch: assert property (p_latch) else $error("latched low alarm lost");
  property p_group;
    @(posedge SYS_CLK) disable iff (RST) flg_reg.invalid |=> ##1 OUTPUT_GROUP_FAULT;
  endproperty
  a_group: assert property (p_group) else $error("group fault missing");
  property p_step;
    @(posedge SYS_CLK) disable iff (RST) tick && ramping && !hold_now
      |=> out_reg - $past(out_reg) == sl_x || $past(out_reg) - out_reg == sl_x;
  endproperty
  a_step: assert property (p_step) else $error("ramp step wrong");
endmodule : aout_channel_ctrl

// ### aout_pkg.sv
// constants and types for the analog output channel control block
package aout_pkg;
  localparam logic [7:0] OFS_REQ = 8'h00;
  localparam logic [7:0] OFS_ECHO = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_LOW = 8'h10;
  localparam logic [7:0] OFS_HIGH = 8'h14;
  localparam logic [7:0] OFS_SLEW = 8'h18;
  localparam logic [7:0] OFS_FAULT_VAL = 8'h1C;
  localparam logic [7:0] OFS_PROG_VAL = 8'h20;
  localparam logic [7:0] OFS_GAIN = 8'h24;
  localparam logic [7:0] OFS_OFFSET = 8'h28;
  localparam logic [7:0] OFS_FULL = 8'h2C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
  localparam logic [7:0] OFS_CODE = 8'h38;
  // ctrl bit positions
  localparam int CTL_RAMP_EN = 0;
  localparam int CTL_SLEW_LATCH = 1;
  localparam int CTL_CLAMP_LATCH = 2;
  localparam int CTL_PCF_EN = 3;
  localparam int CTL_UNL_RAMP = 4;
  localparam int CTL_UNL_CLAMP = 5;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // float reset values: low -10.0, high +10.0, slew 1.0, full scale 20.0, others 0.0
  localparam logic [31:0] LOW_RST = 32'hC1200000;
  localparam logic [31:0] HIGH_RST = 32'h41200000;
  localparam logic [31:0] SLEW_RST = 32'h3F800000;
  localparam logic [31:0] FULL_RST = 32'h41A00000;
  localparam logic [31:0] ZERO_RST = 32'h00000000;
  // fixed point Q16.16 scaling defaults: gain 1.0
  localparam logic [31:0] GAIN_RST = 32'h00010000;
  localparam logic [4:0] IRQ_RST = 5'h00;
  // 0.1 percent of full scale, as a Q24 multiplier
  localparam logic [15:0] HOLD_TOL_MUL = 16'h4189;
  localparam int CLK_HZ = 25000000;
  localparam int UPDATE_NS = 1000000;
  localparam int UPDATE_CYC = (CLK_HZ / 1000) * (UPDATE_NS / 1000) / 1000;
  typedef struct packed {
    logic group_fault;
    logic high;
    logic low;
    logic ramp;
    logic hold;
    logic invalid;
  } flags_t;
  localparam int IRQ_INVALID = 0;
  localparam int IRQ_HOLD_DONE = 1;
  localparam int IRQ_RAMP = 2;
  localparam int IRQ_LOW = 3;
  localparam int IRQ_HIGH = 4;
endpackage : aout_pkg

// ### apb_host_model.sv
// apb master standing in for the controller that sends requests
`timescale 1ns/10ps
module apb_host_model (
  input wire logic SYS_CLK,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [7:0] PADDR,
  output logic [31:0] PWDATA
);
  logic [31:0] rdata;
  logic slverr;
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h00000000;
  end
  // one transfer; request held until pready is seen high at an edge
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= addr;
    PWDATA <= data;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    // no cycle limit here: only the bench watchdog ends a hung wait
    do begin
      @(posedge SYS_CLK);
    end while (PREADY !== 1'b1);
    rdata = PRDATA;
    slverr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : xfer
endmodule : apb_host_model

// ### testbench.sv
// self-checking bench for the analog output channel control block
`timescale 1ns/10ps
module testbench;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic PROGRAM_MODE = 1'b0;
  logic COMM_FAULT = 1'b0;
  logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, OUTPUT_HOLD_FLAG, OUTPUT_GROUP_FAULT, IRQ;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [15:0] DAC_CODE;
  int errors = 0;
  int checked = 0;
  always #20 SYS_CLK = ~SYS_CLK;
  aout_channel_ctrl #(.UPDATE_CYCLES(8)) i_aout_channel_ctrl (.SYS_CLK(SYS_CLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PROGRAM_MODE(PROGRAM_MODE),
    .COMM_FAULT(COMM_FAULT), .DAC_CODE(DAC_CODE), .OUTPUT_HOLD_FLAG(OUTPUT_HOLD_FLAG),
    .OUTPUT_GROUP_FAULT(OUTPUT_GROUP_FAULT), .IRQ(IRQ));
  apb_host_model i_apb_host_model (.SYS_CLK(SYS_CLK), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_apb_host_model.xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    i_apb_host_model.xfer(1'b0, a, 32'h00000000);
    check(i_apb_host_model.rdata & mask, exp);
  endtask : rd
  // several update ticks so the output settles
  task automatic settle;
    repeat (40) @(posedge SYS_CLK);
  endtask : settle
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    errors++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge SYS_CLK);
    RST <= 1'b0;
    rd(aout_pkg::OFS_CTRL, 32'h0000000F, 32'h00000000);
    rd(aout_pkg::OFS_LOW, 32'hFFFFFFFF, 32'hC1200000);
    rd(aout_pkg::OFS_HIGH, 32'hFFFFFFFF, 32'h41200000);
    rd(aout_pkg::OFS_SLEW, 32'hFFFFFFFF, 32'h3F800000);
    rd(aout_pkg::OFS_FULL, 32'hFFFFFFFF, 32'h41A00000);
    rd(aout_pkg::OFS_IRQ_MASK, 32'h0000001F, 32'h00000000);
    i_apb_host_model.xfer(1'b0, 8'h3C, 32'h00000000);
    check({31'h0, i_apb_host_model.slverr}, 32'h00000001);
    $display("test registers done");
    wr(aout_pkg::OFS_REQ, 32'h40000000);
    settle();
    rd(aout_pkg::OFS_ECHO, 32'hFFFFFFFF, 32'h40000000);
    check({16'h0, DAC_CODE}, 32'h00000002);
    wr(aout_pkg::OFS_IRQ_MASK, 32'h00000001);
    wr(aout_pkg::OFS_REQ, 32'h7FC00000);
    settle();
    rd(aout_pkg::OFS_FLAGS, 32'h00000001, 32'h00000001);
    rd(aout_pkg::OFS_ECHO, 32'hFFFFFFFF, 32'h40000000);
    check({31'h0, IRQ}, 32'h00000001);
    wr(aout_pkg::OFS_IRQ_STAT, 32'h00000001);
    repeat (3) @(posedge SYS_CLK);
    check({31'h0, IRQ}, 32'h00000000);
    check({31'h0, OUTPUT_GROUP_FAULT}, 32'h00000001);
    $display("test invalid done");
    wr(aout_pkg::OFS_REQ, 32'hC1400000);
    settle();
    rd(aout_pkg::OFS_FLAGS, 32'h00000008, 32'h00000008);
    rd(aout_pkg::OFS_ECHO, 32'hFFFFFFFF, 32'hC1200000);
    wr(aout_pkg::OFS_REQ, 32'h00000000);
    settle();
    rd(aout_pkg::OFS_FLAGS, 32'h00000008, 32'h00000000);
    wr(aout_pkg::OFS_CTRL, 32'h00000004);
    wr(aout_pkg::OFS_REQ, 32'h41400000);
    settle();
    rd(aout_pkg::OFS_FLAGS, 32'h00000010, 32'h00000010);
    rd(aout_pkg::OFS_ECHO, 32'hFFFFFFFF, 32'h41200000);
    wr(aout_pkg::OFS_REQ, 32'h3F800000);
    settle();
    rd(aout_pkg::OFS_FLAGS, 32'h00000010, 32'h00000010);
    rd(aout_pkg::OFS_ECHO, 32'hFFFFFFFF, 32'h3F800000);
    wr(aout_pkg::OFS_CTRL, 32'h00000024);
    settle();
    rd(aout_pkg::OFS_FLAGS, 32'h00000010, 32'h00000000);
    $display("test clamp done");
    wr(aout_pkg::OFS_CTRL, 32'h00000001);
    wr(aout_pkg::OFS_REQ, 32'h40A00000);
    repeat (6) @(posedge SYS_CLK);
    rd(aout_pkg::OFS_FLAGS, 32'h00000004, 32'h00000004);
    settle();
    rd(aout_pkg::OFS_ECHO, 32'hFFFFFFFF, 32'h40A00000);
    rd(aout_pkg::OFS_FLAGS, 32'h00000004, 32'h00000000);
    $display("test ramp done");
    wr(aout_pkg::OFS_CTRL, 32'h00000000);
    wr(aout_pkg::OFS_PROG_VAL, 32'h40400000);
    wr(aout_pkg::OFS_FAULT_VAL, 32'hBF800000);
    PROGRAM_MODE <= 1'b1;
    settle();
    rd(aout_pkg::OFS_ECHO, 32'hFFFFFFFF, 32'h40400000);
    COMM_FAULT <= 1'b1;
    settle();
    rd(aout_pkg::OFS_ECHO, 32'hFFFFFFFF, 32'h40400000);
    wr(aout_pkg::OFS_CTRL, 32'h00000008);
    settle();
    rd(aout_pkg::OFS_ECHO, 32'hFFFFFFFF, 32'hBF800000);
    COMM_FAULT <= 1'b0;
    settle();
    PROGRAM_MODE <= 1'b0;
    settle();
    check({31'h0, OUTPUT_HOLD_FLAG}, 32'h00000001);
    rd(aout_pkg::OFS_ECHO, 32'hFFFFFFFF, 32'h40400000);
    wr(aout_pkg::OFS_REQ, 32'h40400000);
    settle();
    check({31'h0, OUTPUT_HOLD_FLAG}, 32'h00000000);
    COMM_FAULT <= 1'b1;
    settle();
    rd(aout_pkg::OFS_ECHO, 32'hFFFFFFFF, 32'hBF800000);
    COMM_FAULT <= 1'b0;
    settle();
    rd(aout_pkg::OFS_ECHO, 32'hFFFFFFFF, 32'h40400000);
    $display("test program and hold done");
    test_done();
  end
endmodule : testbench
